// [rsc_pkg.sv]
// Constants shared by the radio state control register block.
// Assumes a 20 MHz device clock; all times are turned into cycles here.
package rsc_pkg;

  // Register offsets on the register port.
  localparam logic [5:0] RSC_ADDR_READBACK = 6'h01;
  localparam logic [5:0] RSC_ADDR_COMMAND = 6'h02;

  // Field positions.
  localparam int RSC_CHANNEL_CHECK_FINISHED_BIT = 7;
  localparam int RSC_CCA_RES_BIT = 6;
  localparam int RSC_CODE_MSB = 4;
  localparam int RSC_TRAC_LSB = 5;

  // Reset values.
  localparam logic [7:0] RSC_READBACK_RST = 8'h00;
  localparam logic [7:0] RSC_COMMAND_RST = 8'h00;

  // Radio state codes.
  localparam logic [4:0] ST_PON = 5'h00;
  localparam logic [4:0] ST_BUSY_RX = 5'h01;
  localparam logic [4:0] ST_BUSY_TX = 5'h02;
  localparam logic [4:0] ST_RX_ON = 5'h06;
  localparam logic [4:0] ST_IDLE = 5'h08;
  localparam logic [4:0] ST_PLL_ON = 5'h09;
  localparam logic [4:0] ST_SLEEP = 5'h0f;
  localparam logic [4:0] ST_AACK_BUSY = 5'h11;
  localparam logic [4:0] ST_ARET_BUSY = 5'h12;
  localparam logic [4:0] ST_AACK_ON = 5'h16;
  localparam logic [4:0] ST_ARET_ON = 5'h19;
  localparam logic [4:0] ST_RX_NOCLK = 5'h1c;
  localparam logic [4:0] ST_AACK_NOCLK = 5'h1d;
  localparam logic [4:0] ST_AACK_BUSY_NOCLK = 5'h1e;
  localparam logic [4:0] ST_PENDING = 5'h1f;

  // Command codes.
  localparam logic [4:0] CMD_NOP = 5'h00;
  localparam logic [4:0] CMD_TX_START = 5'h02;
  localparam logic [4:0] CMD_FORCE_IDLE = 5'h03;
  localparam logic [4:0] CMD_FORCE_PLL = 5'h04;
  localparam logic [4:0] CMD_RX_ON = 5'h06;
  localparam logic [4:0] CMD_IDLE = 5'h08;
  localparam logic [4:0] CMD_PLL_ON = 5'h09;
  localparam logic [4:0] CMD_AACK_ON = 5'h16;
  localparam logic [4:0] CMD_ARET_ON = 5'h19;

  // Timing.
  localparam int CLK_PERIOD_NS = 50;
  localparam int FPLL_TIME_NS = 1000;
  localparam int TRANS_TIME_NS = 2000;
  localparam int SYMBOL_TIME_NS = 50000;
  localparam logic [10:0] FPLL_CYC = 11'(FPLL_TIME_NS / CLK_PERIOD_NS);
  localparam logic [10:0] TRANS_CYC = 11'(TRANS_TIME_NS / CLK_PERIOD_NS);
  localparam logic [10:0] SYMBOL_CYC = 11'(SYMBOL_TIME_NS / CLK_PERIOD_NS);

endpackage

// [rsc_pin_edge.sv]
// Synchroniser and edge detector for the sleep/transmit pin.
// Assumes the pin is asynchronous to I_CLK; edges last one enabled cycle.
`timescale 1ns/1ps
module rsc_pin_edge
  import rsc_pkg::*;
(
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  // Pin and edges
  input wire logic i_pin,
  output logic o_rise,
  output logic o_fall
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } rsc_edge_t;

  rsc_edge_t q, d;

  always_comb begin
    d = q;
    d.s1 = i_pin;
    d.s2 = q.s1;
    d.s3 = q.s2;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= '0;
    end else if (i_ce) begin
      q <= d;
    end
  end

  // Only the second stage and later are looked at.
  assign o_rise = q.s2 & ~q.s3;
  assign o_fall = ~q.s2 & q.s3;

endmodule

// [rsc_regs.sv]
// Radio state readback and state command registers with the state tracker.
// Assumes a same-clock register port and event strobes from the radio.
`timescale 1ns/1ps
// Notes on behaviour
// - Readback bits 4:0 give the settled state code.
// - Extended states report their own codes, including the no-clock ones.
// - An unfinished transition reads as the pending code 0x1f.
// - Bit 7 flags channel check finished, bit 6 its result, bit 5 zero.
// - In sleep the registers are unreachable; host must not read them.
// - A command write starts the coded basic transition.
// - Codes 0x16 and 0x19 enter the automated modes; codes with no listed command are reserved.
// - Frame sending begins exactly one symbol after start transmit.
// - Command register resets to zero, meaning no operation.
// - Bits 7:5 of the command register show the automated result.
// - A rising sleep/transmit pin edge starts some transitions.
// - Forced ready completes within one microsecond.
module rsc_regs
  import rsc_pkg::*;
(
  // Clock, reset, enable
  input wire logic I_CLK,
  input wire logic I_RSTN,
  input wire logic I_CE,
  // Register port
  input wire logic [5:0] I_REG_ADDR,
  input wire logic [7:0] I_REG_WDATA,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  output logic [7:0] O_REG_RDATA,
  output logic O_REG_RVALID,
  // Sleep/transmit pin
  input wire logic I_SLEEP_TRANSMIT_PIN,
  // Radio events
  input wire logic I_RX_START,
  input wire logic I_RX_DONE,
  input wire logic I_TX_DONE,
  input wire logic I_CHANNEL_CHECK_FINISHED,
  input wire logic I_CCA_RESULT,
  input wire logic I_TRAC_VALID,
  input wire logic [2:0] I_TRAC_RESULT,
  // State outputs
  output logic O_TX_BEGIN,
  output logic [4:0] O_STATE_CODE
);

  typedef struct packed {
    logic [4:0] code;
    logic [4:0] tgt;
    logic pend;
    logic txw;
    logic [10:0] cnt;
    logic [4:0] cmd;
    logic [2:0] trac;
    logic channel_check_finished;
    logic cca_res;
    logic [7:0] rdata;
    logic rvalid;
    logic tx_go;
    logic [4:0] shown;
  } rsc_state_t;

  rsc_state_t q, d;
  logic pin_rise;
  logic pin_fall;

  rsc_pin_edge u_pin (
    .i_clk(I_CLK),
    .i_rstn(I_RSTN),
    .i_ce(I_CE),
    .i_pin(I_SLEEP_TRANSMIT_PIN),
    .o_rise(pin_rise),
    .o_fall(pin_fall)
  );

  // Returns {accepted, target} for a state command in a settled state.
  function automatic logic [5:0] cmd_target(input logic [4:0] c,
                                            input logic [4:0] s);
    logic ok;
    logic [4:0] t;
    ok = 1'b0;
    t = s;
    case (c)
      CMD_FORCE_IDLE: begin
        ok = (s != ST_PON) && (s != ST_SLEEP);
        t = ST_IDLE;
      end
      CMD_FORCE_PLL: begin
        ok = (s != ST_PON) && (s != ST_SLEEP) && (s != ST_IDLE) &&
             (s < ST_RX_NOCLK);
        t = ST_PLL_ON;
      end
      CMD_RX_ON: begin
        ok = (s == ST_IDLE) || (s == ST_PLL_ON);
        t = ST_RX_ON;
      end
      CMD_IDLE: begin
        ok = (s == ST_PON) || (s == ST_PLL_ON) || (s == ST_RX_ON);
        t = ST_IDLE;
      end
      CMD_PLL_ON: begin
        ok = (s == ST_IDLE) || (s == ST_RX_ON) || (s == ST_AACK_ON) ||
             (s == ST_ARET_ON);
        t = ST_PLL_ON;
      end
      CMD_AACK_ON, CMD_ARET_ON: begin
        ok = (s == ST_IDLE) || (s == ST_PLL_ON);
        t = c;
      end
      default: begin
        ok = 1'b0;
        t = s;
      end
    endcase
    return {ok, t};
  endfunction

  logic sleeping;
  logic wr_cmd;
  logic rd_stat;
  logic [5:0] acc;

  always_comb begin
    d = q;
    d.tx_go = 1'b0;
    d.rvalid = 1'b0;
    sleeping = (q.code == ST_SLEEP) && !q.pend;
    // Sleep cuts the register port off entirely.
    wr_cmd = I_REG_WR && !sleeping && (I_REG_ADDR == RSC_ADDR_COMMAND);
    rd_stat = I_REG_RD && !sleeping && (I_REG_ADDR == RSC_ADDR_READBACK);
    acc = cmd_target(I_REG_WDATA[4:0], q.code);
    // A finishing check beats the clear from a read in the same cycle.
    if (I_CHANNEL_CHECK_FINISHED) begin
      d.channel_check_finished = 1'b1;
      d.cca_res = I_CCA_RESULT;
    end else if (rd_stat) begin
      d.channel_check_finished = 1'b0;
    end
    if (I_TRAC_VALID) begin
      d.trac = I_TRAC_RESULT;
    end
    if (I_REG_RD && !sleeping) begin
      d.rvalid = 1'b1;
      if (I_REG_ADDR == RSC_ADDR_READBACK) begin
        d.rdata = {q.channel_check_finished, q.cca_res, 1'b0,
                   q.pend ? ST_PENDING : q.code};
      end else if (I_REG_ADDR == RSC_ADDR_COMMAND) begin
        d.rdata = {q.trac, q.cmd};
      end else begin
        d.rdata = 8'h00;
      end
    end
    if (wr_cmd) begin
      d.cmd = I_REG_WDATA[4:0];
    end
    if (q.pend) begin
      // The host waits for a settled code before commanding again.
      if (q.cnt == 11'h000) begin
        d.pend = 1'b0;
        d.code = q.tgt;
      end else begin
        d.cnt = q.cnt - 11'h001;
      end
    end else if (q.txw) begin
      if (q.cnt == 11'h000) begin
        d.txw = 1'b0;
        d.tx_go = 1'b1;
      end else begin
        d.cnt = q.cnt - 11'h001;
      end
    end else if (wr_cmd && (I_REG_WDATA[4:0] == CMD_TX_START)) begin
      if ((q.code == ST_PLL_ON) || (q.code == ST_ARET_ON)) begin
        d.code = (q.code == ST_PLL_ON) ? ST_BUSY_TX : ST_ARET_BUSY;
        d.txw = 1'b1;
        d.cnt = SYMBOL_CYC - 11'h001;
      end
    end else if (wr_cmd && acc[5] && (acc[4:0] != q.code)) begin
      d.pend = 1'b1;
      d.tgt = acc[4:0];
      d.cnt = (I_REG_WDATA[4:0] == CMD_FORCE_PLL) ?
              FPLL_CYC - 11'h001 : TRANS_CYC - 11'h001;
    end else begin
      unique case (q.code)
        ST_PLL_ON, ST_ARET_ON: begin
          if (pin_rise) begin
            d.code = (q.code == ST_PLL_ON) ? ST_BUSY_TX : ST_ARET_BUSY;
            d.txw = 1'b1;
            d.cnt = SYMBOL_CYC - 11'h001;
          end
        end
        ST_IDLE: if (pin_rise) d.code = ST_SLEEP;
        ST_SLEEP: begin
          if (pin_fall) begin
            d.pend = 1'b1;
            d.tgt = ST_IDLE;
            d.cnt = TRANS_CYC - 11'h001;
          end
        end
        ST_RX_ON: begin
          if (pin_rise) d.code = ST_RX_NOCLK;
          else if (I_RX_START) d.code = ST_BUSY_RX;
        end
        ST_AACK_ON: begin
          if (pin_rise) d.code = ST_AACK_NOCLK;
          else if (I_RX_START) d.code = ST_AACK_BUSY;
        end
        ST_RX_NOCLK: begin
          if (pin_fall) d.code = ST_RX_ON;
          else if (I_RX_START) d.code = ST_BUSY_RX;
        end
        ST_AACK_NOCLK: begin
          if (pin_fall) d.code = ST_AACK_ON;
          else if (I_RX_START) d.code = ST_AACK_BUSY_NOCLK;
        end
        ST_BUSY_RX: if (I_RX_DONE) d.code = ST_RX_ON;
        ST_AACK_BUSY: if (I_RX_DONE) d.code = ST_AACK_ON;
        ST_AACK_BUSY_NOCLK: if (I_RX_DONE) d.code = ST_AACK_NOCLK;
        ST_BUSY_TX: if (I_TX_DONE) d.code = ST_PLL_ON;
        ST_ARET_BUSY: if (I_TX_DONE) d.code = ST_ARET_ON;
        default: d.code = q.code;
      endcase
    end
    // The shown code is registered so the output needs no mux after the flop.
    d.shown = d.pend ? ST_PENDING : d.code;
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      q <= '0;
    end else if (I_CE) begin
      q <= d;
    end
  end

  assign O_REG_RDATA = q.rdata;
  assign O_REG_RVALID = q.rvalid;
  assign O_TX_BEGIN = q.tx_go;
  assign O_STATE_CODE = q.shown;

  localparam int SYM_M1 = SYMBOL_TIME_NS / CLK_PERIOD_NS - 1;
  localparam int FPLL_M1 = FPLL_TIME_NS / CLK_PERIOD_NS - 1;

  sequence s_rd_stat;
    I_CE && I_REG_RD && (I_REG_ADDR == RSC_ADDR_READBACK) && !sleeping;
  endsequence
  sequence s_wr(logic [4:0] c);
    I_CE && wr_cmd && (I_REG_WDATA[4:0] == c) && !q.pend && !q.txw;
  endsequence

  property p_pending_code;
    @(posedge I_CLK) disable iff (!I_RSTN)
      (s_rd_stat and q.pend) |=> (O_REG_RDATA[4:0] == ST_PENDING);
  endproperty
  a_pending_code: assert property (p_pending_code)
    else $error("pending transition not shown as 0x1f");

  property p_settled_code;
    @(posedge I_CLK) disable iff (!I_RSTN)
      (s_rd_stat and !q.pend) |=>
        (O_REG_RDATA[4:0] == $past(q.code)) && !O_REG_RDATA[5];
  endproperty
  a_settled_code: assert property (p_settled_code)
    else $error("readback code wrong or reserved bit set");

  property p_sleep_silent;
    @(posedge I_CLK) disable iff (!I_RSTN)
      (I_CE && I_REG_RD && sleeping) |=> !O_REG_RVALID;
  endproperty
  a_sleep_silent: assert property (p_sleep_silent)
    else $error("register answered during sleep");

  property p_cmd_idle;
    @(posedge I_CLK) disable iff (!I_RSTN)
      (s_wr(CMD_IDLE) and (q.code == ST_PLL_ON)) |=>
        q.pend && (q.tgt == ST_IDLE) ##1 (O_STATE_CODE == ST_PENDING);
  endproperty
  a_cmd_idle: assert property (p_cmd_idle)
    else $error("idle command did not start a transition");

  property p_cmd_aack;
    @(posedge I_CLK) disable iff (!I_RSTN)
      (s_wr(CMD_AACK_ON) and (q.code == ST_IDLE)) |=>
        q.pend && (q.tgt == ST_AACK_ON);
  endproperty
  a_cmd_aack: assert property (p_cmd_aack)
    else $error("auto-ack listen command not taken");

  property p_reserved;
    @(posedge I_CLK) disable iff (!I_RSTN)
      (s_wr(5'h05) and (q.code == ST_PLL_ON) and !I_TX_DONE) |=>
        !q.pend && (q.code == ST_PLL_ON);
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved command changed the state");

  property p_status_write;
    @(posedge I_CLK) disable iff (!I_RSTN)
      (I_CE && I_REG_WR && (I_REG_ADDR == RSC_ADDR_READBACK)) |=>
        (q.cmd == $past(q.cmd));
  endproperty
  a_status_write: assert property (p_status_write)
    else $error("readback write disturbed the command field");

  property p_trac_hold;
    @(posedge I_CLK) disable iff (!I_RSTN)
      (I_CE && wr_cmd && !I_TRAC_VALID) |=> (q.trac == $past(q.trac));
  endproperty
  a_trac_hold: assert property (p_trac_hold)
    else $error("result bits were written");

  property p_fpll;
    @(posedge I_CLK) disable iff (!I_RSTN)
      (s_wr(CMD_FORCE_PLL) and (q.code == ST_RX_ON)) |=>
        q.pend && (q.tgt == ST_PLL_ON) && (int'(q.cnt) == FPLL_M1);
  endproperty
  a_fpll: assert property (p_fpll)
    else $error("forced ready not loaded with one microsecond");

  property p_tx_delay;
    @(posedge I_CLK) disable iff (!I_RSTN)
      (s_wr(CMD_TX_START) and (q.code == ST_PLL_ON)) |=>
        (q.code == ST_BUSY_TX) && q.txw && (int'(q.cnt) == SYM_M1);
  endproperty
  a_tx_delay: assert property (p_tx_delay)
    else $error("start transmit not delayed by one symbol");

  property p_pin_tx;
    @(posedge I_CLK) disable iff (!I_RSTN)
      (I_CE && pin_rise && !wr_cmd && !q.pend && !q.txw &&
       (q.code == ST_PLL_ON)) |=> (q.code == ST_BUSY_TX) && q.txw;
  endproperty
  a_pin_tx: assert property (p_pin_tx)
    else $error("pin edge did not start transmit");

endmodule

// [rsc_host_model.sv]
// Host model that reaches the radio state registers one strobe at a time.
// Assumes strobes are taken on rising i_clk and reads answer one cycle later.
`timescale 1ns/1ps
module rsc_host_model
  import rsc_pkg::*;
(
  // Clock
  input wire logic i_clk,
  // Register port
  output logic [5:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_wr,
  output logic o_rd,
  input wire logic [7:0] i_rdata,
  input wire logic i_rvalid
);
  initial begin
    o_addr = 6'h00;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end

  // Address and data are scrambled once released so nothing stale matches.
  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask

  task automatic rd_reg(input logic [5:0] a, output logic [7:0] d,
                        output logic ok);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    @(posedge i_clk);
    ok = i_rvalid;
    d = i_rdata;
  endtask

  // No command follows until a settled code is read back.
  task automatic settle(output logic [7:0] s, output logic ok);
    logic v;
    ok = 1'b0;
    for (int n = 0; n < 100; n++) begin
      rd_reg(RSC_ADDR_READBACK, s, v);
      if (v === 1'b1 && s[4:0] !== ST_PENDING) begin
        ok = 1'b1;
        return;
      end
    end
  endtask
endmodule

// [tb.sv]
// Self-checking bench for the radio state registers with a host model.
// Assumes a 20 MHz clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module tb
  import rsc_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [5:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic rvalid;
  logic pin = 1'b0;
  logic [4:0] ev = 5'h00;
  logic [2:0] trac = 3'h0;
  logic cres = 1'b0;
  logic tx_begin;
  logic [4:0] code;
  int error_cnt = 0;
  int comparisons = 0;
  logic [7:0] s;
  logic ok;
  int k;
  logic [4:0] cur;
  logic [4:0] c;
  logic [4:0] tbl [8] = '{CMD_NOP, CMD_FORCE_IDLE, CMD_FORCE_PLL, CMD_RX_ON,
                          CMD_IDLE, CMD_PLL_ON, CMD_AACK_ON, CMD_ARET_ON};

  always #25 clk = ~clk;

  rsc_host_model h (.i_clk(clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr),
    .o_rd(rd), .i_rdata(rdata), .i_rvalid(rvalid));

  rsc_regs dut (.I_CLK(clk), .I_RSTN(rstn), .I_CE(1'b1), .I_REG_ADDR(addr),
    .I_REG_WDATA(wdata), .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdata),
    .O_REG_RVALID(rvalid), .I_SLEEP_TRANSMIT_PIN(pin), .I_RX_START(ev[0]),
    .I_RX_DONE(ev[1]), .I_TX_DONE(ev[2]), .I_CHANNEL_CHECK_FINISHED(ev[3]),
    .I_CCA_RESULT(cres), .I_TRAC_VALID(ev[4]), .I_TRAC_RESULT(trac),
    .O_TX_BEGIN(tx_begin), .O_STATE_CODE(code));

  task automatic test_done();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_n(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic need(input logic cond);
    if (cond !== 1'b1) begin
      error_cnt++;
      test_done();
    end
  endtask

  // Expected settled state after a command, from the allowed sources.
  function automatic logic [4:0] nxt(logic [4:0] st, logic [4:0] cc);
    case (cc)
      CMD_RX_ON: return (st == ST_IDLE || st == ST_PLL_ON) ? cc : st;
      CMD_IDLE: return (st == ST_PON || st == ST_PLL_ON || st == ST_RX_ON) ?
                       cc : st;
      CMD_PLL_ON: return (st == ST_IDLE || st == ST_RX_ON ||
                          st == ST_AACK_ON || st == ST_ARET_ON) ? cc : st;
      CMD_AACK_ON, CMD_ARET_ON: return (st == ST_IDLE || st == ST_PLL_ON) ?
                                       cc : st;
      CMD_FORCE_IDLE: return (st == ST_PON || st == ST_SLEEP) ? st : ST_IDLE;
      CMD_FORCE_PLL: return (st < 5'h1c && st != ST_IDLE && st != ST_PON) ?
                            ST_PLL_ON : st;
      default: return st;
    endcase
  endfunction

  task automatic cmd(input logic [4:0] cc, input logic [4:0] e);
    h.wr_reg(RSC_ADDR_COMMAND, {3'h0, cc});
    h.settle(s, ok);
    need(ok);
    chk({3'h0, s[4:0]}, {3'h0, e});
    cur = e;
  endtask

  // Counting starts at the edge that takes the request.
  task automatic upto(input logic tx, input logic [4:0] w, output int n);
    for (n = 1; n <= 1200; n++) begin
      @(posedge clk);
      #1;
      if (tx ? tx_begin === 1'b1 : code === w) begin
        return;
      end
    end
    need(1'b0);
  endtask

  task automatic pulse(input int i);
    @(posedge clk);
    ev <= 5'(1 << i);
    @(posedge clk);
    ev <= 5'h00;
  endtask

  task automatic evchk(input int i, input logic [4:0] e);
    pulse(i);
    h.settle(s, ok);
    need(ok);
    chk({3'h0, s[4:0]}, {3'h0, e});
  endtask

  initial begin
    k = $urandom(69060);
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    h.rd_reg(RSC_ADDR_READBACK, s, ok);
    chk(s, RSC_READBACK_RST);
    h.rd_reg(RSC_ADDR_COMMAND, s, ok);
    chk(s, RSC_COMMAND_RST);
    h.rd_reg(6'h3f, s, ok);
    chk({ok, s[6:0]}, 8'h80);
    h.wr_reg(RSC_ADDR_COMMAND, {3'h0, CMD_IDLE});
    h.rd_reg(RSC_ADDR_READBACK, s, ok);
    chk(s, {3'h0, ST_PENDING});
    h.settle(s, ok);
    need(ok);
    chk({3'h0, s[4:0]}, {3'h0, ST_IDLE});
    cmd(CMD_NOP, ST_IDLE);
    h.wr_reg(RSC_ADDR_READBACK, 8'hff);
    cmd(CMD_NOP, ST_IDLE);
    for (int i = 0; i < 40; i++) begin
      k = $urandom % 9;
      c = (k < 8) ? tbl[k] : 5'h0a + 5'($urandom % 6);
      if (c == CMD_FORCE_PLL && cur == ST_IDLE) begin
        c = CMD_NOP;
      end
      cmd(c, nxt(cur, c));
      h.rd_reg(RSC_ADDR_COMMAND, s, ok);
      chk(s, {3'h0, c});
    end
    cmd(CMD_FORCE_IDLE, ST_IDLE);
    cmd(CMD_RX_ON, ST_RX_ON);
    h.wr_reg(RSC_ADDR_COMMAND, {3'h0, CMD_FORCE_PLL});
    upto(1'b0, ST_PLL_ON, k);
    chk_n(k, int'(FPLL_CYC));
    cmd(CMD_RX_ON, ST_RX_ON);
    evchk(0, ST_BUSY_RX);
    evchk(1, ST_RX_ON);
    cres <= 1'($urandom);
    pulse(3);
    h.rd_reg(RSC_ADDR_READBACK, s, ok);
    chk(s, {1'b1, cres, 1'b0, ST_RX_ON});
    h.rd_reg(RSC_ADDR_READBACK, s, ok);
    chk(s, {1'b0, cres, 1'b0, ST_RX_ON});
    pin <= 1'b1;
    upto(1'b0, ST_RX_NOCLK, k);
    chk({3'h0, code}, {3'h0, ST_RX_NOCLK});
    pin <= 1'b0;
    upto(1'b0, ST_RX_ON, k);
    cmd(CMD_PLL_ON, ST_PLL_ON);
    pin <= 1'b1;
    upto(1'b0, ST_BUSY_TX, k);
    upto(1'b1, ST_BUSY_TX, k);
    evchk(2, ST_PLL_ON);
    cmd(CMD_IDLE, ST_IDLE);
    pin <= 1'b0;
    repeat (4) @(posedge clk);
    pin <= 1'b1;
    upto(1'b0, ST_SLEEP, k);
    h.rd_reg(RSC_ADDR_READBACK, s, ok);
    chk({7'h0, ok}, 8'h00);
    pin <= 1'b0;
    cmd(CMD_NOP, ST_IDLE);
    cmd(CMD_AACK_ON, ST_AACK_ON);
    evchk(0, ST_AACK_BUSY);
    evchk(1, ST_AACK_ON);
    pin <= 1'b1;
    upto(1'b0, ST_AACK_NOCLK, k);
    chk({3'h0, code}, {3'h0, ST_AACK_NOCLK});
    evchk(0, ST_AACK_BUSY_NOCLK);
    evchk(1, ST_AACK_NOCLK);
    pin <= 1'b0;
    upto(1'b0, ST_AACK_ON, k);
    chk({3'h0, code}, {3'h0, ST_AACK_ON});
    cmd(CMD_PLL_ON, ST_PLL_ON);
    cmd(CMD_ARET_ON, ST_ARET_ON);
    trac <= 3'($urandom);
    pulse(4);
    h.rd_reg(RSC_ADDR_COMMAND, s, ok);
    chk(s, {trac, CMD_ARET_ON});
    h.wr_reg(RSC_ADDR_COMMAND, {3'h0, CMD_TX_START});
    upto(1'b1, ST_ARET_BUSY, k);
    chk_n(k, int'(SYMBOL_CYC));
    chk({3'h0, code}, {3'h0, ST_ARET_BUSY});
    evchk(2, ST_ARET_ON);
    test_done();
  end
endmodule
